// >>> verilog/uart_status_pkg.sv
// constants, register map and carrier types of the serial port status block
package uart_status_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] DATA_OFS = 8'h00;
    localparam logic [7:0] IEN_OFS = 8'h04;
    localparam logic [7:0] FCTL_OFS = 8'h08;
    localparam logic [7:0] MSR_OFS = 8'h14;
    localparam logic [7:0] FSR_OFS = 8'h18;
    localparam logic [7:0] ISR_OFS = 8'h1c;
    localparam logic [7:0] TOR_OFS = 8'h20;
    localparam logic [7:0] BAUD_OFS = 8'h24;
    // reset values and writable masks
    localparam logic [31:0] TOR_RESET = 32'h00000000;
    localparam logic [31:0] BAUD_RESET = 32'h0f000000;
    localparam logic [31:0] TOR_MASK = 32'h0000ffff;
    localparam logic [31:0] BAUD_MASK = 32'h3f00ffff;
    // fifo status field positions
    localparam int FSR_RX_OVER = 0;
    localparam int FSR_ADDR = 3;
    localparam int FSR_PARITY = 4;
    localparam int FSR_FRAMING = 5;
    localparam int FSR_BREAK = 6;
    localparam int FSR_TX_OVER = 24;
    // fifo control field positions
    localparam int FCTL_RX_RST = 1;
    localparam int FCTL_TX_RST = 2;
    localparam int FCTL_TRIG_LSB = 4;
    localparam int FCTL_PARITY_EN = 8;
    localparam int FCTL_RS485 = 9;
    // modem status field positions
    localparam int MSR_CTS_CHG = 0;
    localparam int MSR_CTS_STATE = 4;
    // fifo sizes and levels
    localparam int RX_DEPTH = 15;
    localparam int TX_DEPTH = 16;
    localparam logic [5:0] FULL_LEVEL = 6'h0e;
    localparam logic [5:0] TRIG_1 = 6'h01;
    localparam logic [5:0] TRIG_4 = 6'h04;
    localparam logic [5:0] TRIG_8 = 6'h08;
    localparam logic [5:0] TRIG_14 = 6'h0e;
    // baud oversampling factor without the extended divider
    localparam logic [4:0] M_PLAIN = 5'h10;
    // interrupt source positions in the status register
    localparam int INT_LSB = 8;
    localparam int N_INT = 6;

    typedef struct packed {
        logic [1:0] rsv_hi;
        logic x_en;
        logic x_one;
        logic [3:0] div_x;
        logic [7:0] rsv_mid;
        logic [15:0] baud_divisor;
    } baud_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [7:0] gap;
        logic [7:0] idle_cmp;
    } tor_t;

    typedef enum logic [1:0] {TX_IDLE, TX_FRAME, TX_GAP} tx_state_t;
    typedef enum logic {RX_IDLE, RX_FRAME} rx_state_t;
endpackage

// >>> verilog/uart_status_irq_baud.sv
// serial port status, interrupt flags, receive time-out, transmit gap and baud divider
// Function
// - tx empty bit sets when last byte enters shifter, clears on data write
// - tx count rises per written byte, falls per byte sent to shifter
// - rx full bit is high while rx occupancy exceeds fourteen
// - rx empty sets when last byte read, clears on any new character
// - rx count rises per received character, falls per software read
// - break flag sets on line low beyond one character; write-one or rx reset clears
// - framing and parity error flags; write-one or rx reset clears
// - in multi-drop mode ninth bit one sets address flag; write-one clears
// - character arriving into full rx fifo sets overflow; write-one clears
// - each interrupt indicator is its flag ANDed with its enable
// - buffer error flag is OR of tx and rx overflow flags
// - time-out flag sets when non-empty and idle count hits comparator
// - modem flag follows the clear-to-send change flag
// - line error flag is OR of break, framing, parity flags and, in multi-drop mode only, the address flag
// - holding-empty flag sets on last byte to shifter, clears on write
// - rx available flag high while rx count at or above trigger level
// - trigger code 0,1,2,3 gives 1,4,8,14 bytes
// - programmable idle gap between one stop bit and the next start
// - idle counter restarts on each new word; new word or empty clears time-out
// - baud is clock over M times divisor plus two, M sixteen by default
// - extended divider uses M equal to divider-x plus one, kept at eight or more
// - divide-by-one uses M equal one, divisor kept at three or more
//
// Design decision made here: strobed register access.
module uart_status_irq_baud
    import uart_status_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // serial line
    input wire logic rxd,
    input wire logic cts_n,
    output logic txd,
    // interrupt
    output logic irq
);
    // registers and state
    baud_t baud;
    tor_t tor;
    logic [5:0] ien;
    logic [3:0] trig_code;
    logic parity_en, rs485;
    logic rxd_meta, rxd_s, rxd_prev, cts_meta, cts_s, cts_prev;
    logic [16:0] div_cnt;
    logic [4:0] osc_cnt;
    logic [4:0] low_cnt;
    rx_state_t rx_state;
    logic [4:0] samp_cnt;
    logic [3:0] bit_idx;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic [7:0] rx_mem [RX_DEPTH];
    logic [3:0] rx_wp, rx_rp;
    logic [5:0] rx_count;
    logic [7:0] tx_mem [TX_DEPTH];
    logic [3:0] tx_wp, tx_rp;
    logic [5:0] tx_count;
    tx_state_t tx_state;
    logic [9:0] tx_shift;
    logic [3:0] tx_left;
    logic [7:0] gap_cnt;
    logic [7:0] idle_cnt;
    logic brk, fe, pe, addr_seen, rx_over, tx_over, cts_chg;
    logic rx_empty, tx_empty, tout;

    // register decode
    wire wr_data = wr && addr == DATA_OFS;
    wire rd_data = rd && addr == DATA_OFS;
    wire wr_fsr = wr && addr == FSR_OFS;
    wire wr_fctl = wr && addr == FCTL_OFS;
    wire rx_rst = wr_fctl && wdata[FCTL_RX_RST];
    wire tx_rst = wr_fctl && wdata[FCTL_TX_RST];
    wire extra = parity_en || rs485;
    wire rx_line = rxd_s;

    // baud timing: sample tick every brd+2 clocks, bit tick every M samples
    wire [16:0] div_top = {1'b0, baud.baud_divisor} + 17'h00001;
    wire samp_tick = div_cnt >= div_top;
    wire [4:0] m_val = !baud.x_en ? M_PLAIN :
                       baud.x_one ? 5'h01 :
                       {1'b0, baud.div_x} + 5'h01;
    wire [4:0] m_last = m_val - 5'h01;
    wire bit_tick = samp_tick && osc_cnt >= m_last;

    // receiver events
    wire [3:0] stop_idx = extra ? 4'h a : 4'h9;
    wire rx_sample = rx_state == RX_FRAME && samp_tick && samp_cnt == 5'h00;
    wire rx_stop = rx_sample && bit_idx == stop_idx;
    wire rx_full = rx_count > FULL_LEVEL;
    wire rx_push_ok = rx_stop && !rx_full;
    wire rx_pop = rd_data && rx_count != 6'h00;
    wire [4:0] frame_len = extra ? 5'h0b : 5'h0a;
    // break once low for a whole character plus one bit time
    wire brk_det = bit_tick && !rx_line && low_cnt == frame_len;
    wire fe_det = rx_stop && !rx_line;
    wire pe_det = rx_stop && parity_en && !rs485 && ((^rx_data) ^ rx_ninth);
    wire addr_det = rx_stop && rs485 && rx_ninth;
    wire over_det = rx_stop && rx_full;

    // transmitter events
    wire tx_full = tx_count > FULL_LEVEL;
    wire tx_push_ok = wr_data && !tx_full;
    wire tx_pop = tx_state == TX_IDLE && bit_tick && tx_count != 6'h00 && !tx_rst;
    wire [7:0] tx_byte = tx_mem[tx_rp];
    wire tx_par = ~^tx_byte ^ 1'b1;
    wire tx_done = tx_state == TX_IDLE && tx_count == 6'h00;

    // trigger level decode; reserved codes behave as the top level
    wire [5:0] trig_level = trig_code == 4'h0 ? TRIG_1 :
                            trig_code == 4'h1 ? TRIG_4 :
                            trig_code == 4'h2 ? TRIG_8 : TRIG_14;

    // idle counter and time-out: activity restarts counting
    wire rx_activity = rx_push_ok || rx_pop;
    wire tout_set = bit_tick && rx_count != 6'h00 && !rx_activity &&
                    idle_cnt != 8'hff && idle_cnt + 8'h01 == tor.idle_cmp;
    wire tout_clr = rx_activity || rx_count == 6'h00 || rx_rst;
    wire [7:0] next_idle_cnt = rx_activity ? 8'h00 :
                               (bit_tick && idle_cnt != 8'hff) ? idle_cnt + 8'h01 : idle_cnt;

    // sticky flags: a set in the cycle of its clear wins
    wire next_brk = brk_det || (brk && !(wr_fsr && wdata[FSR_BREAK]) && !rx_rst);
    wire next_fe = fe_det || (fe && !(wr_fsr && wdata[FSR_FRAMING]) && !rx_rst);
    wire next_pe = pe_det || (pe && !(wr_fsr && wdata[FSR_PARITY]) && !rx_rst);
    wire next_addr = addr_det || (addr_seen && !(wr_fsr && wdata[FSR_ADDR]));
    wire next_rx_over = over_det || (rx_over && !(wr_fsr && wdata[FSR_RX_OVER]));
    wire next_tx_over = (wr_data && tx_full) ||
                        (tx_over && !(wr_fsr && wdata[FSR_TX_OVER]));
    wire cts_chg_det = cts_s != cts_prev;
    wire next_cts_chg = cts_chg_det ||
                        (cts_chg && !(wr && addr == MSR_OFS && wdata[MSR_CTS_CHG]));
    // a character landing as the last byte is read keeps the fifo non-empty
    wire next_rx_empty = (rx_pop && rx_count == 6'h01 && !rx_push_ok) || rx_rst ||
                         (rx_empty && !rx_push_ok);
    wire next_tx_empty = (tx_pop && tx_count == 6'h01) || tx_rst ||
                         (tx_empty && !tx_push_ok);
    wire next_tout = tout_set || (tout && !tout_clr);

    // interrupt flags and indicators
    wire buf_err = rx_over || tx_over;
    wire line_err = brk || fe || pe || (rs485 && addr_seen);
    wire modem_if = cts_chg;
    wire rx_avail = rx_count >= trig_level;
    wire [5:0] flags = {buf_err, tout, modem_if, line_err, tx_empty, rx_avail};
    wire [5:0] ints = flags & ien;
    wire te_flag = tx_done && tx_empty;

    // read data
    wire [31:0] fsr_word = {3'h0, te_flag, 3'h0, tx_over, tx_full, tx_empty, tx_count,
                            rx_full, rx_empty, rx_count, 1'b0, brk, fe, pe, addr_seen,
                            2'h0, rx_over};
    wire [31:0] rd_mux = addr == DATA_OFS ? {24'h000000, rx_mem[rx_rp]} :
                         addr == IEN_OFS ? {26'h0, ien} :
                         addr == FCTL_OFS ? {22'h0, rs485, parity_en, trig_code, 4'h0} :
                         addr == MSR_OFS ? {27'h0, cts_s, 3'h0, cts_chg} :
                         addr == FSR_OFS ? fsr_word :
                         addr == ISR_OFS ? {18'h0, ints, 2'h0, flags} :
                         addr == TOR_OFS ? tor :
                         addr == BAUD_OFS ? baud : 32'h00000000;

    // software registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            baud <= BAUD_RESET;
            tor <= TOR_RESET;
            ien <= 6'h00;
            trig_code <= 4'h0;
            parity_en <= 1'b0;
            rs485 <= 1'b0;
        end else if (wr) begin
            if (addr == BAUD_OFS) baud <= wdata & BAUD_MASK;
            if (addr == TOR_OFS) tor <= wdata & TOR_MASK;
            if (addr == IEN_OFS) ien <= wdata[5:0];
            if (addr == FCTL_OFS) begin
                trig_code <= wdata[FCTL_TRIG_LSB +: 4];
                parity_en <= wdata[FCTL_PARITY_EN];
                rs485 <= wdata[FCTL_RS485];
            end
        end
    end

    // read port, answer one cycle after the strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) rdata <= 32'h00000000;
        else rdata <= rd ? rd_mux : 32'h00000000;
    end

    // pin synchronisers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {rxd_meta, rxd_s, rxd_prev} <= 3'h7;
            {cts_meta, cts_s, cts_prev} <= 3'h7;
        end else begin
            rxd_meta <= rxd;
            rxd_s <= rxd_meta;
            rxd_prev <= rxd_s;
            cts_meta <= cts_n;
            cts_s <= cts_meta;
            cts_prev <= cts_s;
        end
    end

    // baud divider and bit-time counters
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= 17'h00000;
            osc_cnt <= 5'h00;
            low_cnt <= 5'h00;
        end else begin
            div_cnt <= samp_tick ? 17'h00000 : div_cnt + 17'h00001;
            if (samp_tick) osc_cnt <= bit_tick ? 5'h00 : osc_cnt + 5'h01;
            if (rx_line) low_cnt <= 5'h00;
            else if (bit_tick && low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h01;
        end
    end

    // receiver: start on falling edge, sample mid-bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_state <= RX_IDLE;
            samp_cnt <= 5'h00;
            bit_idx <= 4'h0;
            rx_data <= 8'h00;
            rx_ninth <= 1'b0;
        end else if (rx_rst) begin
            rx_state <= RX_IDLE;
        end else begin
            unique case (rx_state)
                RX_IDLE: begin
                    if (rxd_prev && !rx_line) begin
                        rx_state <= RX_FRAME;
                        samp_cnt <= {1'b0, m_val[4:1]};
                        bit_idx <= 4'h0;
                    end
                end
                RX_FRAME: begin
                    if (samp_tick) samp_cnt <= samp_cnt == 5'h00 ? m_last : samp_cnt - 5'h01;
                    if (rx_sample) begin
                        bit_idx <= bit_idx + 4'h1;
                        // a glitch that is high at mid start bit is not a start
                        if ((bit_idx == 4'h0 && rx_line) || rx_stop) rx_state <= RX_IDLE;
                        if (bit_idx >= 4'h1 && bit_idx <= 4'h8) rx_data <= {rx_line, rx_data[7:1]};
                        if (bit_idx == 4'h9 && extra) rx_ninth <= rx_line;
                        if (bit_idx == 4'h0) rx_ninth <= 1'b0;
                    end
                end
            endcase
        end
    end

    // receive fifo
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_count <= 6'h00;
        end else if (rx_rst) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_count <= 6'h00;
        end else begin
            if (rx_push_ok) rx_wp <= rx_wp == 4'(RX_DEPTH - 1) ? 4'h0 : rx_wp + 4'h1;
            if (rx_pop) rx_rp <= rx_rp == 4'(RX_DEPTH - 1) ? 4'h0 : rx_rp + 4'h1;
            if (rx_push_ok && !rx_pop) rx_count <= rx_count + 6'h01;
            else if (rx_pop && !rx_push_ok) rx_count <= rx_count - 6'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (rx_push_ok) rx_mem[rx_wp] <= rx_data;
        if (tx_push_ok) tx_mem[tx_wp] <= wdata[7:0];
    end

    // transmit fifo
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_count <= 6'h00;
        end else if (tx_rst) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_count <= 6'h00;
        end else begin
            if (tx_push_ok) tx_wp <= tx_wp + 4'h1;
            if (tx_pop) tx_rp <= tx_rp + 4'h1;
            if (tx_push_ok && !tx_pop) tx_count <= tx_count + 6'h01;
            else if (tx_pop && !tx_push_ok) tx_count <= tx_count - 6'h01;
        end
    end

    // transmitter: bits on the free-running bit tick, then the gap
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_state <= TX_IDLE;
            tx_shift <= 10'h3ff;
            tx_left <= 4'h0;
            gap_cnt <= 8'h00;
            txd <= 1'b1;
        end else if (tx_rst) begin
            tx_state <= TX_IDLE;
            txd <= 1'b1;
        end else begin
            unique case (tx_state)
                TX_IDLE: begin
                    if (tx_pop) begin
                        txd <= 1'b0;
                        tx_shift <= extra ? {1'b1, tx_par, tx_byte} : {2'h3, tx_byte};
                        tx_left <= 4'(frame_len - 5'h01);
                        tx_state <= TX_FRAME;
                    end
                end
                TX_FRAME: begin
                    if (bit_tick) begin
                        txd <= tx_shift[0];
                        tx_shift <= {1'b1, tx_shift[9:1]};
                        tx_left <= tx_left - 4'h1;
                        // leave as the stop bit goes out: idle needs one tick to pop
                        if (tx_left == 4'h1) begin
                            gap_cnt <= tor.gap;
                            tx_state <= tor.gap == 8'h00 ? TX_IDLE : TX_GAP;
                        end
                    end
                end
                TX_GAP: begin
                    if (bit_tick) begin
                        gap_cnt <= gap_cnt - 8'h01;
                        if (gap_cnt == 8'h01) tx_state <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // flags and interrupt output
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {brk, fe, pe, addr_seen, rx_over, tx_over, cts_chg} <= 7'h00;
            {rx_empty, tx_empty, tout} <= 3'h6;
            idle_cnt <= 8'h00;
            irq <= 1'b0;
        end else begin
            {brk, fe, pe, addr_seen} <= {next_brk, next_fe, next_pe, next_addr};
            {rx_over, tx_over, cts_chg} <= {next_rx_over, next_tx_over, next_cts_chg};
            {rx_empty, tx_empty, tout} <= {next_rx_empty, next_tx_empty, next_tout};
            idle_cnt <= next_idle_cnt;
            irq <= |ints;
        end
    end

    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    AST_TX_EMPTY_SET: assert property (tx_pop && tx_count == 6'h01 |=> tx_empty)
        else $error("tx empty not set after last byte left");
    AST_TX_COUNT: assert property (tx_push_ok && !tx_pop && !tx_rst
        |=> tx_count == $past(tx_count) + 6'h01) else $error("tx count did not rise");
    AST_RX_FULL_READ: assert property (rd && addr == FSR_OFS
        |=> rdata[15] == ($past(rx_count) > 6'h0e)) else $error("rx full bit wrong");
    AST_RX_EMPTY_CLR: assert property (rx_push_ok |=> !rx_empty)
        else $error("rx empty stayed set after new character");
    AST_RX_COUNT: assert property (rx_pop && !rx_push_ok && !rx_rst
        |=> rx_count == $past(rx_count) - 6'h01) else $error("rx count did not fall");
    AST_BREAK: assert property (brk_det |=> brk)
        else $error("break flag not set");
    AST_FRAMING: assert property (rx_stop && !rx_line |=> fe ##1 fe || !nrst)
        else $error("framing flag not set on low stop bit");
    AST_OVERFLOW: assert property (rx_stop && rx_full |=> rx_over && rx_count == 6'h0f)
        else $error("overflow not flagged or count changed");
    AST_ISR_READ: assert property (rd && addr == ISR_OFS
        |=> rdata[13:8] == ($past(flags) & $past(ien))) else $error("indicator wrong");
    AST_IRQ: assert property (irq == $past(|ints))
        else $error("interrupt output does not follow indicators");
    AST_TOUT_CLR: assert property (rx_push_ok |=> !tout)
        else $error("time-out survived a new word");

    COV_RX_PUSH: cover property (rx_push_ok ##[1:1000] rx_pop);
    COV_TX_LAST: cover property (tx_pop && tx_count == 6'h01);
    COV_TOUT: cover property (tout_set);
    COV_BREAK: cover property (brk_det);
endmodule

// >>> dv/serial_peer.sv
// serial device model driving the receive and clear-to-send pins
module serial_peer (
    // clock
    input wire logic mclk,
    // pins toward the block
    output logic rxd,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int bit_clks = 32;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b1;
    end
    // level held for whole bit times, counted on the block clock
    task automatic hold(input logic lvl, input int n);
        rxd <= lvl;
        repeat (n * bit_clks) @(posedge mclk);
    endtask
    // start, nb payload bits lsb first, then one idle bit so frames never merge
    task automatic send(input logic [9:0] bits, input int nb);
        hold(1'b0, 1);
        for (int i = 0; i < nb; i++) hold(bits[i], 1);
        hold(1'b1, 1);
    endtask
    task automatic line_break();
        hold(1'b0, 12);
        hold(1'b1, 2);
    endtask
    task automatic cts_flip();
        cts_n <= ~cts_n;
    endtask
endmodule

// >>> dv/uart_status_irq_baud_tb_top.sv
// self-checking bench for the serial port status block
module uart_status_irq_baud_tb_top import uart_status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata, v;
    logic rxd, cts_n, txd, irq;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    int lo, hi;
    int lvl[4] = '{1, 4, 8, 14};
    int bits[3] = '{32, 5, 18};
    logic [31:0] bauds[3] = '{32'h0f000000, 32'h30000003, 32'h28000000};
    logic [7:0] ofs[5] = '{ISR_OFS, TOR_OFS, BAUD_OFS, FSR_OFS, 8'h3c};
    logic [31:0] rst_v[5] = '{32'h2, 32'h0, 32'h0f000000, 32'h10404000, 32'h0};

    always #2.5 mclk = ~mclk;

    uart_status_irq_baud dut_u (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rxd(rxd), .cts_n(cts_n), .txd(txd), .irq(irq));
    serial_peer peer_u (.mclk(mclk), .rxd(rxd), .cts_n(cts_n));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    // bounded so a stuck line ends in a mismatch, not a hang
    task automatic until_txd(input logic lvl_v, output int n);
        n = 0;
        while (txd !== lvl_v && n < 5000) begin
            @(posedge mclk);
            n++;
        end
    endtask
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_errors++;
            close_out();
        end
    end

    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd_reg(ofs[i]);
            chk(v, rst_v[i], "reset value");
        end
        wr_reg(TOR_OFS, 32'hffffffff);
        rd_reg(TOR_OFS);
        chk(v, 32'h0000ffff, "tor access");
        wr_reg(BAUD_OFS, 32'hffffffff);
        rd_reg(BAUD_OFS);
        chk(v, 32'h3f00ffff, "baud access");
        wr_reg(BAUD_OFS, 32'h0f000000);
        wr_reg(TOR_OFS, 32'h0);
        $display("test registers done");
        wr_reg(IEN_OFS, 32'h21);
        for (int c = 0; c < 4; c++) begin
            wr_reg(FCTL_OFS, (c << FCTL_TRIG_LSB) | 32'h2);
            for (int n = 1; n <= ((c == 3) ? 16 : lvl[c]); n++) begin
                peer_u.send({2'b01, 8'(8'h40 + n)}, 9);
                rd_reg(FSR_OFS);
                chk(v[13:8], (n > 15) ? 15 : n, "rx count");
                chk({v[15], v[14], v[0]}, {n > 14, 1'b0, n > 15}, "rx flags");
                rd_reg(ISR_OFS);
                chk({v[8], v[0]}, {2{n >= lvl[c]}}, "rx avail");
            end
        end
        chk({v[13], v[5], irq}, 3'b111, "buffer error");
        rd_reg(DATA_OFS);
        chk(v[7:0], 8'h41, "first byte");
        rd_reg(FSR_OFS);
        chk({v[15], v[13:8]}, 7'h0e, "after pop");
        wr_reg(FSR_OFS, 32'h1);
        rd_reg(ISR_OFS);
        chk({v[13], v[5], v[0]}, 3'b001, "overflow cleared");
        rd_reg(DATA_OFS);
        rd_reg(ISR_OFS);
        chk(v[0], 1'b0, "below trigger");
        repeat (13) rd_reg(DATA_OFS);
        rd_reg(FSR_OFS);
        chk({v[14], v[13:8]}, 7'h40, "drained");
        $display("test rx fifo done");
        wr_reg(IEN_OFS, 32'h4);
        peer_u.send(10'h055, 9);
        rd_reg(FSR_OFS);
        chk({v[14], v[5]}, 2'b01, "framing");
        rd_reg(ISR_OFS);
        chk({v[10], v[2], irq}, 3'b111, "line error");
        wr_reg(FSR_OFS, 32'h20);
        rd_reg(ISR_OFS);
        chk({v[2], irq}, 2'b00, "line cleared");
        wr_reg(FCTL_OFS, 32'h100);
        peer_u.send(10'h201, 10);
        rd_reg(FSR_OFS);
        chk(v[4], 1'b1, "parity");
        wr_reg(FCTL_OFS, 32'h2);
        rd_reg(FSR_OFS);
        chk(v[6:4], 3'b000, "rx reset clears");
        wr_reg(FCTL_OFS, 32'h200);
        peer_u.send(10'h312, 10);
        rd_reg(FSR_OFS);
        chk(v[3], 1'b1, "address byte");
        rd_reg(ISR_OFS);
        chk(v[2], 1'b1, "address line");
        wr_reg(FSR_OFS, 32'h8);
        rd_reg(ISR_OFS);
        chk(v[2], 1'b0, "address cleared");
        wr_reg(FCTL_OFS, 32'h2);
        peer_u.line_break();
        rd_reg(FSR_OFS);
        chk(v[6], 1'b1, "break");
        wr_reg(FSR_OFS, 32'h40);
        rd_reg(FSR_OFS);
        chk(v[6], 1'b0, "break cleared");
        wr_reg(FCTL_OFS, 32'h2);
        $display("test line errors done");
        wr_reg(IEN_OFS, 32'h8);
        peer_u.cts_flip();
        repeat (4) @(posedge mclk);
        rd_reg(MSR_OFS);
        chk(v[0], 1'b1, "cts change");
        rd_reg(ISR_OFS);
        chk({v[11], v[3], irq}, 3'b111, "modem");
        wr_reg(MSR_OFS, 32'h1);
        rd_reg(ISR_OFS);
        chk({v[3], irq}, 2'b00, "modem cleared");
        $display("test modem done");
        wr_reg(TOR_OFS, 32'h0228);
        wr_reg(IEN_OFS, 32'h10);
        peer_u.send(10'h155, 9);
        rd_reg(ISR_OFS);
        chk(v[4], 1'b0, "no early timeout");
        repeat (1400) @(posedge mclk);
        rd_reg(ISR_OFS);
        chk({v[12], v[4], irq}, 3'b111, "timeout");
        rd_reg(DATA_OFS);
        rd_reg(ISR_OFS);
        chk(v[4], 1'b0, "timeout cleared");
        $display("test timeout done");
        wr_reg(IEN_OFS, 32'h2);
        for (int k = 0; k < 3; k++) begin
            wr_reg(BAUD_OFS, bauds[k]);
            wr_reg(DATA_OFS, 32'hff);
            until_txd(1'b0, lo);
            wr_reg(DATA_OFS, 32'hff);
            wr_reg(DATA_OFS, 32'hff);
            rd_reg(FSR_OFS);
            chk({v[22], v[21:16]}, 7'h02, "tx queued");
            rd_reg(ISR_OFS);
            chk(v[1], 1'b0, "holding full");
            until_txd(1'b1, lo);
            until_txd(1'b0, lo);
            until_txd(1'b1, lo);
            until_txd(1'b0, hi);
            chk(lo, bits[k], "bit time");
            chk(lo + hi, 12 * bits[k], "frame and gap");
            rd_reg(FSR_OFS);
            chk({v[22], v[21:16]}, 7'h40, "tx drained");
            rd_reg(ISR_OFS);
            chk({v[9], v[1], irq}, 3'b111, "holding empty");
            repeat (14 * bits[k]) @(posedge mclk);
        end
        for (int i = 0; i < 18; i++) wr_reg(DATA_OFS, 32'h0);
        rd_reg(FSR_OFS);
        chk({v[24:23], v[21:16]}, 8'hcf, "tx overflow");
        rd_reg(ISR_OFS);
        chk(v[5], 1'b1, "tx buffer error");
        wr_reg(FSR_OFS, 32'h01000000);
        rd_reg(ISR_OFS);
        chk(v[5], 1'b0, "tx overflow cleared");
        wr_reg(FCTL_OFS, 32'h4);
        $display("test transmit done");
        close_out();
    end
endmodule
